// *** common/remote_status_map.vh ***
// constants for the remote status and port configuration block
`ifndef REMOTE_STATUS_MAP_VH
`define REMOTE_STATUS_MAP_VH
// device status word fields
`define DSW_UNITS_HI 15
`define DSW_UNITS_LO 12
`define DSW_PWR_LIM 8
`define DSW_CUR_LIM 7
`define DSW_LOCKOUT 6
`define DSW_LOCAL 5
`define DSW_REMOTE 4
`define DSW_OUT_DIS 1
`define DSW_OV_SHUT 0
// interface status word fields (serial layout, 16 bits)
`define ISB_PAR_EN 7
`define ISB_PAR_ODD 6
`define ISB_STOP2 5
`define ISB_DATA8 4
`define ISB_ECHO 11
`define ISB_HW_HS 9
`define ISB_SW_HS 8
// query codes
`define Q_STATUS 3'h0
`define Q_ISB 3'h1
`define Q_IDENT 3'h2
`define Q_PORT 3'h3
`define Q_VERSION 3'h4
// port kinds
`define PK_NONE 3'h0
`define PK_RS232 3'h1
`define PK_RS485 3'h2
`define PK_USB 3'h3
`define PK_GPIB 3'h4
`define PK_LAN 3'h5
// baud codes 0..9 map to 1200..115200
`define BAUD_CODES 4'ha
`define BAUD_RESET 4'h3
// parity, handshake, timeout codes
`define PAR_NONE 2'h0
`define PAR_ODD 2'h1
`define PAR_EVEN 2'h2
`define HS_NONE 2'h0
`define HS_HW 2'h1
`define HS_SW 2'h2
`define TMO_MAX 8'h64
`define TMO_RESET 8'h01
// response framing
`define RSP_MAX 6'h28
`endif

// *** hw/port_cfg_slot.v ***
// one serial port configuration slot
`timescale 1ns/1ps
`include "remote_status_map.vh"
module port_cfg_slot (
  input wire mclk,
  input wire rst,
  input wire ce,
  input wire [2:0] kind,
  input wire wr,
  input wire [3:0] baud,
  input wire [1:0] parity,
  input wire data8,
  input wire stop2,
  input wire [1:0] hs,
  input wire echo,
  input wire [7:0] tmo,
  output reg [22:0] cfg_q,
  output reg rejected_q
);
  reg ok;
  ////////////////////////////////////////////////////////////////////////////////
  // validate a write against the port kind
  always @*
  begin
    ok = (baud < `BAUD_CODES) && (parity != 2'h3);
    if (kind == `PK_RS485)
      ok = ok && (tmo <= `TMO_MAX);
    else if (kind == `PK_RS232 || kind == `PK_USB)
      ok = ok && (hs != 2'h3);
    else
      ok = 1'b0; // bus and network ports take no settings
  end
  ////////////////////////////////////////////////////////////////////////////////
  // settings live only in flops, lost at power cycle until saved elsewhere
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cfg_q <= {`BAUD_RESET, `PAR_NONE, 1'b1, 1'b0, `HS_NONE, 1'b0, `TMO_RESET, 4'h0};
      rejected_q <= 1'b0;
    end
    else if (ce && wr)
    begin
      rejected_q <= ~ok;
      if (ok)
        cfg_q <= {baud, parity, data8, stop2, hs, echo, tmo, 4'h0}; // live at once
    end
  end
endmodule // port_cfg_slot

// *** hw/remote_status_cfg.v ***
// remote command response logic: status word, interface status, id, port config
`timescale 1ns/1ps
`include "remote_status_map.vh"
module remote_status_cfg #(
  parameter [7:0] ID_MFR = 8'h41,   // arbitrary identity letter
  parameter [7:0] ID_MODEL = 8'h42, // arbitrary identity letter
  parameter [7:0] ID_REV = 8'h31    // arbitrary revision digit
) (
  input wire mclk,
  input wire rst,
  input wire ce,
  input wire cmd_valid,
  input wire [2:0] cmd_query,
  input wire [1:0] cmd_port,
  input wire cmd_write,
  input wire [3:0] cmd_baud,
  input wire [1:0] cmd_parity,
  input wire cmd_data8,
  input wire cmd_stop2,
  input wire [1:0] cmd_hs,
  input wire cmd_echo,
  input wire [7:0] cmd_tmo,
  input wire [2:0] active_port,
  input wire [8:0] port_kinds,
  input wire [3:0] unit_count,
  input wire ms_enabled,
  input wire pwr_limit_pin,
  input wire cur_limit_pin,
  input wire front_panel_lockout,
  input wire local_mode,
  input wire out_disabled_pin,
  input wire overvoltage_shutdown_pin,
  input wire [7:0] isb_flags,
  input wire [3:0] baud_sel_unused,
  output reg busy_q,
  output reg rsp_valid_q,
  output reg [7:0] rsp_char_q,
  output reg rsp_last_q,
  output reg cmd_err_q,
  output reg [15:0] device_status_word_q,
  output reg [3:0] baud_live1_q,
  output reg [3:0] baud_live2_q,
  output reg [3:0] baud_live3_q
);
  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers for asynchronous status inputs
  reg [7:0] s1_q;
  reg [7:0] s2_q;
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s1_q <= 8'h00;
      s2_q <= 8'h00;
    end
    else if (ce)
    begin
      s1_q <= {ms_enabled, pwr_limit_pin, cur_limit_pin, front_panel_lockout,
               local_mode, out_disabled_pin, overvoltage_shutdown_pin, 1'b0};
      s2_q <= s1_q;
    end
  end
  wire ms_en = s2_q[7];

  ////////////////////////////////////////////////////////////////////////////////
  // device status word, reserved bits held at zero
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
      device_status_word_q <= 16'h0000;
    else if (ce)
    begin
      device_status_word_q[15:12] <= ms_en ? unit_count : 4'h0;
      device_status_word_q[11:9] <= 3'h0;
      device_status_word_q[8] <= s2_q[6];
      device_status_word_q[7] <= s2_q[5];
      device_status_word_q[6] <= s2_q[4];
      device_status_word_q[5] <= s2_q[3];
      device_status_word_q[4] <= ~s2_q[3];
      device_status_word_q[3:2] <= 2'h0;
      device_status_word_q[1] <= s2_q[2];
      device_status_word_q[0] <= s2_q[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // three port slots
  wire [22:0] cfg [0:2];
  wire [2:0] rej;
  wire [2:0] wr_sel;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : slot
      assign wr_sel[g] = ce && cmd_valid && !busy_q && cmd_query == `Q_PORT && cmd_write
                         && cmd_port == g + 1;
      port_cfg_slot u_slot (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .kind(port_kinds[3*g+2:3*g]),
        .wr(wr_sel[g]),
        .baud(cmd_baud),
        .parity(cmd_parity),
        .data8(cmd_data8),
        .stop2(cmd_stop2),
        .hs(cmd_hs),
        .echo(cmd_echo),
        .tmo(cmd_tmo),
        .cfg_q(cfg[g]),
        .rejected_q(rej[g])
      );
    end
  endgenerate

  // live baud codes, updated the cycle after the write lands
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      baud_live1_q <= `BAUD_RESET;
      baud_live2_q <= `BAUD_RESET;
      baud_live3_q <= `BAUD_RESET;
    end
    else if (ce)
    begin
      baud_live1_q <= cfg[0][22:19];
      baud_live2_q <= cfg[1][22:19];
      baud_live3_q <= cfg[2][22:19];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // response builder: text held in a small array, streamed out one char per cycle
  reg [7:0] buf_q [0:39];
  reg [5:0] len_q;
  reg [5:0] idx_q;
  reg [2:0] q_q;
  reg [1:0] p_q;
  reg [1:0] st_q;
  localparam ST_IDLE = 2'h0;
  localparam ST_LOAD = 2'h1;
  localparam ST_SEND = 2'h2;

  // serial interface status word from the active port's settings
  wire [1:0] ap = (active_port[1:0] == 2'h0) ? 2'h0 : active_port[1:0] - 2'h1;
  wire [22:0] acfg = cfg[ap];
  wire [2:0] akind = port_kinds[3*ap+:3];
  wire a_gpib = (akind == `PK_GPIB);
  // handshake and echo mean nothing on the multidrop port, so they read zero there
  wire a_p2p = (akind != `PK_RS485);
  wire [15:0] isb16 = {4'h0, acfg[12] & a_p2p, 1'b0,
                       (acfg[14:13] == `HS_HW) & a_p2p, (acfg[14:13] == `HS_SW) & a_p2p,
                       acfg[18:17] != `PAR_NONE, acfg[18:17] == `PAR_ODD,
                       acfg[15], acfg[16], isb_flags[3:0]};
  wire [15:0] qword = (q_q == `Q_STATUS) ? device_status_word_q
                      : (a_gpib ? {8'h00, isb_flags} : isb16);
  wire [4:0] nbits = (q_q == `Q_ISB && a_gpib) ? 5'h08 : 5'h10;
  wire [2:0] pk = port_kinds[3*p_q+:3];
  wire [22:0] pc = cfg[p_q];

  integer i;
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= ST_IDLE;
      busy_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_char_q <= 8'h00;
      rsp_last_q <= 1'b0;
      cmd_err_q <= 1'b0;
      len_q <= 6'h00;
      idx_q <= 6'h00;
      q_q <= 3'h0;
      p_q <= 2'h0;
    end
    else if (ce)
    begin
      case (st_q)
        ST_IDLE:
        begin
          rsp_valid_q <= 1'b0;
          rsp_last_q <= 1'b0;
          busy_q <= 1'b0; // drops only once the last character has stood its cycle
          if (cmd_valid && !busy_q)
          begin
            q_q <= cmd_query;
            p_q <= cmd_port - 2'h1;
            cmd_err_q <= (cmd_query == `Q_PORT && cmd_port == 2'h0) || cmd_query > `Q_VERSION;
            if (!(cmd_query == `Q_PORT && cmd_write) && cmd_query <= `Q_VERSION
                && !(cmd_query == `Q_PORT && cmd_port == 2'h0))
            begin
              busy_q <= 1'b1;
              st_q <= ST_LOAD;
            end
          end
        end
        ST_LOAD:
        begin
          for (i = 0; i < 40; i = i + 1)
            buf_q[i] <= 8'h20;
          idx_q <= 6'h00;
          case (q_q)
            `Q_STATUS, `Q_ISB:
            begin
              buf_q[0] <= 8'h53; // "S" then echo name
              buf_q[1] <= 8'h54;
              buf_q[2] <= (q_q == `Q_STATUS) ? 8'h41 : 8'h42;
              buf_q[3] <= 8'h2c;
              for (i = 0; i < 16; i = i + 1)
                if (i < nbits)
                  buf_q[4+i] <= qword[nbits-1-i] ? 8'h31 : 8'h30; // msb first
              len_q <= 6'h04 + {1'b0, nbits};
            end
            `Q_IDENT:
            begin
              buf_q[0] <= 8'h49;
              buf_q[1] <= 8'h44;
              buf_q[2] <= 8'h2c;
              buf_q[3] <= ID_MFR;
              buf_q[4] <= 8'h2c;
              buf_q[5] <= ID_MODEL;
              buf_q[6] <= 8'h2c;
              buf_q[7] <= ID_REV;
              len_q <= 6'h08;
            end
            `Q_VERSION:
            begin
              buf_q[0] <= ID_REV;
              len_q <= 6'h01;
            end
            default:
            begin
              // port query: echo, kind digit, then baud code digit and the other settings as letters and digits
              buf_q[0] <= 8'h50;
              buf_q[1] <= 8'h43;
              buf_q[2] <= 8'h31 + {6'h00, p_q};
              buf_q[3] <= 8'h2c;
              if (pk == `PK_NONE)
              begin
                buf_q[4] <= 8'h45; // empty indication
                len_q <= 6'h05;
              end
              else if (pk == `PK_GPIB || pk == `PK_LAN)
              begin
                buf_q[4] <= 8'h30 + {5'h00, pk}; // type only
                len_q <= 6'h05;
              end
              else
              begin
                buf_q[4] <= 8'h30 + {5'h00, pk};
                buf_q[5] <= 8'h2c;
                buf_q[6] <= 8'h30 + {4'h0, pc[22:19]};
                buf_q[7] <= 8'h2c;
                buf_q[8] <= (pc[18:17] == `PAR_ODD) ? 8'h4f
                            : (pc[18:17] == `PAR_EVEN ? 8'h45 : 8'h4e);
                buf_q[9] <= 8'h2c;
                buf_q[10] <= pc[16] ? 8'h38 : 8'h37;
                buf_q[11] <= 8'h2c;
                buf_q[12] <= pc[15] ? 8'h32 : 8'h31;
                buf_q[13] <= 8'h2c;
                if (pk == `PK_RS485)
                begin
                  buf_q[14] <= 8'h30 + {4'h0, pc[11:8]}; // timeout hex
                  buf_q[15] <= 8'h30 + {4'h0, pc[7:4]};
                  len_q <= 6'h10;
                end
                else
                begin
                  buf_q[14] <= (pc[14:13] == `HS_HW) ? 8'h48
                               : (pc[14:13] == `HS_SW ? 8'h53 : 8'h4e);
                  buf_q[15] <= 8'h2c;
                  buf_q[16] <= pc[12] ? 8'h45 : 8'h4e;
                  len_q <= 6'h11;
                end
              end
            end
          endcase
          st_q <= ST_SEND;
        end
        ST_SEND:
        begin
          rsp_valid_q <= 1'b1;
          rsp_char_q <= buf_q[idx_q];
          rsp_last_q <= (idx_q == len_q - 6'h01);
          idx_q <= idx_q + 6'h01;
          if (idx_q == len_q - 6'h01)
          begin
            st_q <= ST_IDLE;
          end
        end
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end
endmodule // remote_status_cfg

// *** sim/host_model.sv ***
// host side model: issues remote commands and gathers response characters
`timescale 1ns/1ps
module host_model (
  input wire mclk,
  input wire busy_q,
  input wire rsp_valid_q,
  input wire [7:0] rsp_char_q,
  input wire rsp_last_q,
  output reg cmd_valid = 1'b0,
  output reg [2:0] cmd_query = 3'h0,
  output reg [1:0] cmd_port = 2'h0,
  output reg cmd_write = 1'b0,
  output reg [18:0] cmd_set = 19'h0
);
  reg [7:0] rbuf [0:39];
  integer rn = 0;
  integer k;
  ////////////////////////////////////////////////////////////////////////////////
  // keep every response character in arrival order
  always @(posedge mclk)
  begin
    if (cmd_valid)
      rn <= 0;
    else if (rsp_valid_q)
    begin
      rbuf[rn] <= rsp_char_q;
      rn <= rn + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one command; settings are lost at power off, saving them is up to the host
  task send(input [2:0] q, input [1:0] p, input w, input [18:0] s);
    begin
      @(posedge mclk);
      for (k = 0; k < 80 && busy_q; k = k + 1) @(posedge mclk);
      {cmd_valid, cmd_query, cmd_port, cmd_write, cmd_set} <= {1'b1, q, p, w, s};
      @(posedge mclk);
      // released lines carry inverted data so a stale value never passes for a live one
      {cmd_valid, cmd_query, cmd_port, cmd_write, cmd_set} <= {1'b0, ~q, ~p, ~w, ~s};
      for (k = 0; k < 80 && !w && !rsp_last_q; k = k + 1) @(posedge mclk);
      #1;
    end
  endtask
endmodule // host_model

// *** sim/remote_status_cfg_asserts.sv ***
// concurrent checks on the remote status and port configuration block
`timescale 1ns/1ps
module remote_status_cfg_asserts (
  input wire mclk,
  input wire rst,
  input wire ce,
  input wire cmd_valid,
  input wire [2:0] cmd_query,
  input wire [1:0] cmd_port,
  input wire cmd_write,
  input wire [3:0] cmd_baud,
  input wire [1:0] cmd_parity,
  input wire [1:0] cmd_hs,
  input wire [8:0] port_kinds,
  input wire busy_q,
  input wire rsp_valid_q,
  input wire [7:0] rsp_char_q,
  input wire rsp_last_q,
  input wire [15:0] device_status_word_q,
  input wire [3:0] baud_live1_q,
  input wire [3:0] baud_live3_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  // a request counts only when the block is idle and enabled
  wire take = ce && cmd_valid && !busy_q;
  wire wr1 = take && cmd_query == 3'h3 && cmd_write && cmd_port == 2'h1;
  wire wr3 = take && cmd_query == 3'h3 && cmd_write && cmd_port == 2'h3;
  wire ok1 = (port_kinds[2:0] == 3'h1 || port_kinds[2:0] == 3'h3) && cmd_parity != 2'h3;
  ////////////////////////////////////////////////////////////////////////////////
  a_rsvd_zero:
    assert property (device_status_word_q[11:9] == 3'h0 && device_status_word_q[3:2] == 2'h0)
    else $error("reserved status bits set");
  a_status_first:
    assert property (take && cmd_query == 3'h0 |-> ##3 rsp_valid_q && rsp_char_q == 8'h53)
    else $error("status reply does not open on time");
  a_status_len:
    assert property (take && cmd_query == 3'h0 |-> ##22 rsp_last_q)
    else $error("status reply length wrong");
  a_ident_busy:
    assert property (take && cmd_query == 3'h2 |=> busy_q)
    else $error("identify not taken");
  a_valid_busy:
    assert property (rsp_valid_q |-> busy_q)
    else $error("character outside busy");
  a_last_ends:
    assert property (rsp_last_q |-> rsp_valid_q ##1 !busy_q)
    else $error("busy outlasts last character");
  a_baud_live:
    assert property (wr1 && ok1 && cmd_hs != 2'h3 && cmd_baud < 4'ha
      |-> ##2 baud_live1_q == $past(cmd_baud, 2))
    else $error("new baud not live");
  a_baud_refuse:
    assert property (wr1 && cmd_baud >= 4'ha |-> ##2 $stable(baud_live1_q))
    else $error("unlisted baud accepted");
  a_bus_refuse:
    assert property (wr3 && port_kinds[8:6] >= 3'h4 |-> ##2 $stable(baud_live3_q))
    else $error("bus or network port took settings");
endmodule // remote_status_cfg_asserts

// *** sim/test_remote_status_and_port_config.sv ***
// self-checking bench for the remote status and port configuration block
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks_done = checks_done + 1; \
  if ((a) !== (e)) begin mismatches = mismatches + 1; \
  $display("Error %s expected %0h seen %0h", n, e, a); end end
module test_remote_status_and_port_config;
  reg mclk = 1'b0, rst = 1'b1, ce = 1'b1;
  reg [2:0] active_port = 3'h1;
  reg [8:0] port_kinds = 9'h111; // bus, multidrop, point-to-point
  reg [3:0] unit_count = 4'h1, baud_sel_unused = 4'h0;
  reg ms_enabled = 1'b1, pwr_limit_pin = 1'b0, cur_limit_pin = 1'b0;
  reg front_panel_lockout = 1'b0, local_mode = 1'b1;
  reg out_disabled_pin = 1'b0, overvoltage_shutdown_pin = 1'b0;
  reg [7:0] isb_flags = 8'h05;
  reg [15:0] sw;
  wire cmd_valid, cmd_write, busy_q, rsp_valid_q, rsp_last_q, cmd_err_q;
  wire [2:0] cmd_query;
  wire [1:0] cmd_port;
  wire [18:0] cmd_set;
  wire [7:0] rsp_char_q;
  wire [15:0] device_status_word_q;
  wire [3:0] baud_live1_q, baud_live2_q, baud_live3_q;
  integer mismatches = 0, checks_done = 0, k;
  ////////////////////////////////////////////////////////////////////////////////
  remote_status_cfg i_remote_status_cfg (.mclk, .rst, .ce, .cmd_valid, .cmd_query, .cmd_port,
    .cmd_write, .cmd_baud(cmd_set[18:15]), .cmd_parity(cmd_set[14:13]), .cmd_data8(cmd_set[12]),
    .cmd_stop2(cmd_set[11]), .cmd_hs(cmd_set[10:9]), .cmd_echo(cmd_set[8]),
    .cmd_tmo(cmd_set[7:0]), .active_port, .port_kinds, .unit_count, .ms_enabled,
    .pwr_limit_pin, .cur_limit_pin, .front_panel_lockout, .local_mode, .out_disabled_pin,
    .overvoltage_shutdown_pin, .isb_flags, .baud_sel_unused, .busy_q, .rsp_valid_q,
    .rsp_char_q, .rsp_last_q, .cmd_err_q, .device_status_word_q, .baud_live1_q,
    .baud_live2_q, .baud_live3_q);
  host_model i_host_model (.mclk, .busy_q, .rsp_valid_q, .rsp_char_q, .rsp_last_q, .cmd_valid,
    .cmd_query, .cmd_port, .cmd_write, .cmd_set);
  ////////////////////////////////////////////////////////////////////////////////
  // 25 MHz clock
  initial
  begin
    forever #20 mclk = ~mclk;
  end
  function [7:0] rb(input integer i);
    rb = i_host_model.rbuf[i];
  endfunction
  task rd(input [2:0] q, input [1:0] p);
    i_host_model.send(q, p, 1'b0, 19'h0);
  endtask
  // a write lands on the edge that takes it; the live baud follows one edge later
  task wr(input [1:0] p, input [18:0] s);
    begin
      i_host_model.send(3'h3, p, 1'b1, s);
      repeat (2) @(posedge mclk);
      #1;
    end
  endtask
  task txt(input [63:0] t, input integer n);
    for (k = 0; k < n; k = k + 1) `CHK("char", t[8 * (n - 1 - k) +: 8], rb(k))
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_status;
    begin
      @(posedge mclk);
      {unit_count, ms_enabled, pwr_limit_pin, cur_limit_pin} <= {4'h2, 3'b110};
      {front_panel_lockout, local_mode, out_disabled_pin, overvoltage_shutdown_pin} <= 4'b1011;
      repeat (6) @(posedge mclk);
      #1;
      sw = 16'h2153;
      `CHK("status", sw, device_status_word_q)
      rd(3'h0, 2'h0);
      `CHK("sta len", 20, i_host_model.rn)
      txt("STA,", 4);
      for (k = 0; k < 16; k = k + 1) `CHK("sta bit", {7'h18, sw[15 - k]}, rb(4 + k))
      @(posedge mclk);
      {unit_count, ms_enabled, pwr_limit_pin, cur_limit_pin} <= {4'h5, 3'b001};
      {front_panel_lockout, local_mode, out_disabled_pin, overvoltage_shutdown_pin} <= 4'b0100;
      repeat (6) @(posedge mclk);
      #1;
      `CHK("status", 16'h00a0, device_status_word_q)
    end
  endtask
  // serial interface status bit b sits at character 19 - b
  task t_isb;
    begin
      rd(3'h1, 2'h0);
      `CHK("isb len", 20, i_host_model.rn)
      `CHK("par en", 8'h30, rb(12))
      `CHK("data8", 8'h31, rb(15))
      wr(2'h1, {4'h9, 2'h1, 1'b0, 1'b1, 2'h1, 1'b1, 8'h01});
      rd(3'h1, 2'h0);
      `CHK("odd", 8'h31, rb(13))
      `CHK("stop2", 8'h31, rb(14))
      `CHK("data7", 8'h30, rb(15))
      `CHK("echo", 8'h31, rb(8))
      `CHK("hw hs", 8'h31, rb(10))
      wr(2'h1, {4'h9, 2'h2, 1'b1, 1'b0, 2'h2, 1'b0, 8'h01});
      rd(3'h1, 2'h0);
      `CHK("even", 8'h30, rb(13))
      `CHK("sw hs", 8'h31, rb(11))
      `CHK("echo off", 8'h30, rb(8))
      @(posedge mclk);
      active_port <= 3'h3;
      rd(3'h1, 2'h0);
      `CHK("bus len", 12, i_host_model.rn)
      `CHK("bus flag", 8'h31, rb(11))
    end
  endtask
  task t_ports;
    begin
      for (k = 0; k < 10; k = k + 1)
      begin
        wr(2'h1, {k[3:0], 15'h1001});
        `CHK("baud1", k[3:0], baud_live1_q)
      end
      wr(2'h1, {4'ha, 15'h1001});
      `CHK("bad baud", 4'h9, baud_live1_q)
      wr(2'h1, {4'h0, 15'h7001});
      `CHK("bad parity", 4'h9, baud_live1_q)
      wr(2'h2, {4'h1, 15'h1032});
      `CHK("baud2", 4'h1, baud_live2_q)
      rd(3'h3, 2'h2);
      txt("PC2,2", 5);
      `CHK("tmo hi", 8'h33, rb(i_host_model.rn - 2))
      `CHK("tmo lo", 8'h32, rb(i_host_model.rn - 1))
      wr(2'h3, {4'h0, 15'h1001});
      `CHK("bus port", 4'h3, baud_live3_q)
      @(posedge mclk);
      port_kinds <= 9'h151;
      wr(2'h3, {4'h0, 15'h1001});
      `CHK("net port", 4'h3, baud_live3_q)
      @(posedge mclk);
      port_kinds <= 9'h013;
      rd(3'h3, 2'h3);
      `CHK("empty", 8'h45, rb(i_host_model.rn - 1))
      wr(2'h1, {4'h2, 15'h1001});
      `CHK("usb baud", 4'h2, baud_live1_q)
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // the tests need under 300 cycles; the limit allows 5000, over sixteen times that
  initial
  begin
    #200000;
    mismatches = mismatches + 1;
    print_verdict;
  end
  initial
  begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    `CHK("live3", 4'h3, baud_live3_q)
    t_status;
    t_isb;
    t_ports;
    rd(3'h2, 2'h0);
    txt("ID,A,B,1", 8);
    `CHK("id err", 1'b0, cmd_err_q)
    // port index zero is no port: flagged, nothing written, no reply
    i_host_model.send(3'h3, 2'h0, 1'b1, 19'h0);
    `CHK("port0 err", 1'b1, cmd_err_q)
    rd(3'h4, 2'h0);
    `CHK("ver len", 1, i_host_model.rn)
    txt("1", 1);
    `CHK("ver err", 1'b0, cmd_err_q)
    print_verdict;
  end
endmodule // test_remote_status_and_port_config
bind remote_status_cfg remote_status_cfg_asserts i_chk (.mclk, .rst, .ce, .cmd_valid,
  .cmd_query, .cmd_port, .cmd_write, .cmd_baud, .cmd_parity, .cmd_hs, .port_kinds, .busy_q,
  .rsp_valid_q, .rsp_char_q, .rsp_last_q, .device_status_word_q, .baud_live1_q,
  .baud_live3_q);
